//--- rtl/ccg_cfg.svh
`ifndef CCG_CFG_SVH
`define CCG_CFG_SVH

// ---------------------------------------------------------------
// sizes and clock
// ---------------------------------------------------------------
`define CCG_NCH           20
`define CCG_NREF          4
`define CCG_CLK_MHZ       200

// ---------------------------------------------------------------
// timing, each time in its own unit, then the derived count
// ---------------------------------------------------------------
`define CCG_IVL_NS        15600
`define CCG_IVL_CYC       (`CCG_IVL_NS * `CCG_CLK_MHZ / 1000)
`define CCG_W62_NS        9800
`define CCG_W62_CYC       (`CCG_W62_NS * `CCG_CLK_MHZ / 1000)
`define CCG_W50_NS        7800
`define CCG_W50_CYC       (`CCG_W50_NS * `CCG_CLK_MHZ / 1000)
`define CCG_DLY_MAX_NS    3400
`define CCG_DLY_STEPS     8
`define CCG_DLY_STEP_CYC  (`CCG_DLY_MAX_NS * `CCG_CLK_MHZ / 1000 / (`CCG_DLY_STEPS - 1))
`define CCG_BYTE_BITS     8
`define CCG_REF_PER_US    250
`define CCG_REF_TO_CYC    (2 * `CCG_REF_PER_US * `CCG_CLK_MHZ)
`define CCG_BLINK_MS      250
`define CCG_BLINK_CYC     (`CCG_BLINK_MS * `CCG_CLK_MHZ * 1000)

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define CCG_OFS_CTRL      8'h00
`define CCG_OFS_CHEN      8'h04
`define CCG_OFS_DUTY      8'h08
`define CCG_OFS_DLY_LO    8'h0c
`define CCG_OFS_DLY_HI    8'h10
`define CCG_OFS_FAIL      8'h14
`define CCG_OFS_REF       8'h18
`define CCG_OFS_IRQ_ST    8'h1c
`define CCG_OFS_IRQ_CLR   8'h20
`define CCG_OFS_IRQ_EN    8'h24

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define CCG_CTRL_SEL_LSB  0
`define CCG_CTRL_EN_BIT   2
`define CCG_CTRL_FW_BIT   3
`define CCG_CTRL_IGN_BIT  4
`define CCG_DLY_PER_WORD  10
`define CCG_IRQ_REF_LSB   20
`define CCG_CTRL_RST      5'h04
`define CCG_CHEN_RST      20'hfffff
`define CCG_DUTY_RST      20'h00000
`define CCG_DLY_RST       3'h0

`endif

//--- rtl/ccg_pkg.sv
package ccg_pkg;

    // module status indicator modes
    typedef enum logic [1:0] {
        CCG_ST_OK,
        CCG_ST_BLINK,
        CCG_ST_FAIL
    } ccg_mod_st_t;

    // per-channel phase delay step code
    typedef logic [2:0] ccg_dly_t;

endpackage

//--- rtl/ccg_top.sv
`timescale 1ns/1ps
`include "ccg_cfg.svh"

// Overview of operation
// - twenty tip/ring output pairs, all timed from one selected reference.
// - each channel has its own relay enable that disconnects only that channel.
// - per-channel duty select, 50/50 or 62.5/37.5.
// - per-channel phase delay, zero to 3.4 us in eight steps.
// - byte boundary and polarity sequence follow the selected 4 kHz reference.
// - every channel has its own independent failure monitor.
// - fail on low amplitude, sensed polarity not matching the driven wire or missing return to zero.
// - bipolar return-to-zero coding, successive marks alternate polarity.
// - pulse every 15.6 us; width 9.8 us or 7.8 us by duty setting.
// - source A/B lamp green selected, amber faulty, off good and unselected.
// - bypass lamp green selected, amber faulty, off ignored or good and unselected.
// - expansion lamp green only when selected in expansion shelf, else amber/off.
// - output fault lamp on while any channel failed, off when all good.
// - status lamp green ok, blinking disabled or loading, amber on failure.
// - reference chosen from A, B, C; D only in an expansion shelf.
module ccg_top
    import ccg_pkg::*;
#(
    parameter int NCH         = `CCG_NCH,
    parameter int REF_TIMEOUT = `CCG_REF_TO_CYC,
    parameter int BLINK_HALF  = `CCG_BLINK_CYC
)(
    input  wire logic            clk_i,
    input  wire logic            rstn_i,
    input  wire logic [7:0]      addr_i,
    input  wire logic [31:0]     wdata_i,
    input  wire logic            we_i,
    input  wire logic            re_i,
    output logic      [31:0]     rdata_o,
    input  wire logic [3:0]      ref_clk_i,
    input  wire logic            expansion_shelf_i,
    input  wire logic [NCH-1:0]  mon_amp_ok_i,
    input  wire logic [NCH-1:0]  mon_pos_i,
    input  wire logic [NCH-1:0]  mon_neg_i,
    output logic      [NCH-1:0]  tip_output_o,
    output logic      [NCH-1:0]  ring_output_o,
    output logic      [NCH-1:0]  relay_on_o,
    output logic      [3:0]      src_green_o,
    output logic      [3:0]      src_amber_o,
    output logic                 out_fault_o,
    output logic                 stat_green_o,
    output logic                 stat_amber_o,
    output logic                 irq_o
);

    // ---------------------------------------------------------------
    // constants
    // ---------------------------------------------------------------
    localparam logic [11:0] IVL_LAST = 12'(`CCG_IVL_CYC - 1);
    localparam logic [11:0] W62      = 12'(`CCG_W62_CYC);
    localparam logic [11:0] W50      = 12'(`CCG_W50_CYC);
    localparam logic [11:0] STEP     = 12'(`CCG_DLY_STEP_CYC);
    localparam logic [2:0]  BIT_LAST = 3'(`CCG_BYTE_BITS - 1);
    localparam int          WDW      = $clog2(REF_TIMEOUT + 1);
    localparam int          BKW      = $clog2(BLINK_HALF + 1);
    localparam int          NEV      = `CCG_IRQ_REF_LSB + 4;

    // address match, shared by every decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // ---------------------------------------------------------------
    // register bus decode
    // ---------------------------------------------------------------
    wire wr_ctrl  = we_i && hit(addr_i, `CCG_OFS_CTRL);
    wire wr_chen  = we_i && hit(addr_i, `CCG_OFS_CHEN);
    wire wr_duty  = we_i && hit(addr_i, `CCG_OFS_DUTY);
    wire wr_dlylo = we_i && hit(addr_i, `CCG_OFS_DLY_LO);
    wire wr_dlyhi = we_i && hit(addr_i, `CCG_OFS_DLY_HI);
    wire wr_clr   = we_i && hit(addr_i, `CCG_OFS_IRQ_CLR);
    wire wr_ien   = we_i && hit(addr_i, `CCG_OFS_IRQ_EN);

    logic [4:0]     ctrl_reg;
    logic [NCH-1:0] chen_reg;
    logic [NCH-1:0] duty_reg;
    logic [NEV-1:0] ien_reg;
    logic [NEV-1:0] ist_reg;
    ccg_dly_t       dly_reg [NCH];

    wire [1:0] sel_code  = ctrl_reg[`CCG_CTRL_SEL_LSB +: 2];
    wire       mod_en    = ctrl_reg[`CCG_CTRL_EN_BIT];
    wire       fw_load   = ctrl_reg[`CCG_CTRL_FW_BIT];
    wire       byp_ign   = ctrl_reg[`CCG_CTRL_IGN_BIT];

    // software configuration
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_reg <= `CCG_CTRL_RST;
            chen_reg <= NCH'(`CCG_CHEN_RST);
            duty_reg <= NCH'(`CCG_DUTY_RST);
            ien_reg  <= '0;
        end else begin
            if (wr_ctrl) ctrl_reg <= wdata_i[4:0];
            if (wr_chen) chen_reg <= wdata_i[NCH-1:0];
            if (wr_duty) duty_reg <= wdata_i[NCH-1:0];
            if (wr_ien)  ien_reg  <= wdata_i[NEV-1:0];
        end
    end

    // ---------------------------------------------------------------
    // reference watch and selection
    // ---------------------------------------------------------------
    logic [3:0] ref_d_reg;
    logic [3:0] ref_good_reg;
    wire  [3:0] ref_rise = ref_clk_i & ~ref_d_reg;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) ref_d_reg <= 4'h0;
        else         ref_d_reg <= ref_clk_i;
    end

    // a reference is good while edges keep arriving within the timeout
    genvar r;
    generate
        for (r = 0; r < 4; r++) begin : g_ref
            logic [WDW-1:0] wd_reg;
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    wd_reg          <= '0;
                    ref_good_reg[r] <= 1'b0;
                end else if (ref_rise[r]) begin
                    wd_reg          <= '0;
                    ref_good_reg[r] <= 1'b1;
                end else if (wd_reg == WDW'(REF_TIMEOUT)) begin
                    ref_good_reg[r] <= 1'b0;
                end else begin
                    wd_reg <= wd_reg + 1'b1;
                end
            end
        end
    endgenerate

    // D only exists in an expansion shelf; C may be ignored by software
    wire [3:0] src_avail = {expansion_shelf_i, ~byp_ign, 2'b11};
    wire [3:0] sel_oh    = 4'(4'h1 << sel_code) & src_avail;
    wire       sel_ok    = |(sel_oh & ref_good_reg);
    wire       align     = |(sel_oh & ref_good_reg & ref_rise);

    // ---------------------------------------------------------------
    // pulse timebase
    // ---------------------------------------------------------------
    logic [11:0] ph_reg;
    logic [2:0]  bit_reg;
    wire         ivl_end = ph_reg == IVL_LAST;

    // reference edge restarts the byte at bit 0, positive mark
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ph_reg  <= 12'h000;
            bit_reg <= 3'h0;
        end else if (align) begin
            ph_reg  <= 12'h000;
            bit_reg <= 3'h0;
        end else if (ivl_end) begin
            ph_reg  <= 12'h000;
            bit_reg <= (bit_reg == BIT_LAST) ? 3'h0 : bit_reg + 3'h1;
        end else begin
            ph_reg  <= ph_reg + 12'h001;
        end
    end

    // odd bits carry the negative mark; eight bits keep it even
    wire neg_mark = bit_reg[0];

    // ---------------------------------------------------------------
    // output channels and monitors
    // ---------------------------------------------------------------
    logic [NCH-1:0] fail_reg;
    logic [NCH-1:0] fail_d_reg;
    logic [31:0]    dly_lo_w;
    logic [31:0]    dly_hi_w;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            localparam int LANE = (g % `CCG_DLY_PER_WORD) * 3;
            localparam bit HI   = g >= `CCG_DLY_PER_WORD;
            logic        s_amp_reg;
            logic        s_pol_reg;
            logic        s_rz_reg;
            wire         wr_me  = HI ? wr_dlyhi : wr_dlylo;
            wire  [11:0] start  = 12'(dly_reg[g]) * STEP;
            wire  [11:0] width  = duty_reg[g] ? W62 : W50;
            wire         mark   = ph_reg >= start && ph_reg < start + width;
            wire         live   = chen_reg[g] && mod_en;
            wire         drv    = tip_output_o[g] | ring_output_o[g];
            wire         pol_ok = ring_output_o[g] ? mon_neg_i[g] && !mon_pos_i[g]
                                                   : mon_pos_i[g] && !mon_neg_i[g];
            wire         rz_ok  = !drv && !mon_pos_i[g] && !mon_neg_i[g];

            if (HI) begin : g_hi
                assign dly_hi_w[LANE +: 3] = dly_reg[g];
            end else begin : g_lo
                assign dly_lo_w[LANE +: 3] = dly_reg[g];
            end

            // delay code from its lane of the low or high word
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i)    dly_reg[g] <= `CCG_DLY_RST;
                else if (wr_me) dly_reg[g] <= wdata_i[LANE +: 3];
            end

            // drive: positive on tip, negative on ring, both low between
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    tip_output_o[g]  <= 1'b0;
                    ring_output_o[g] <= 1'b0;
                    relay_on_o[g]    <= 1'b0;
                end else begin
                    tip_output_o[g]  <= live && mark && !neg_mark;
                    ring_output_o[g] <= live && mark && neg_mark;
                    relay_on_o[g]    <= live;
                end
            end

            // evidence gathered over one interval, judged at its end
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    s_amp_reg   <= 1'b0;
                    s_pol_reg   <= 1'b0;
                    s_rz_reg    <= 1'b0;
                    fail_reg[g] <= 1'b0;
                end else if (align || ivl_end) begin
                    s_amp_reg <= 1'b0;
                    s_pol_reg <= 1'b0;
                    s_rz_reg  <= 1'b0;
                    if (!relay_on_o[g])
                        fail_reg[g] <= 1'b0;
                    else if (ivl_end)
                        fail_reg[g] <= !(s_amp_reg && s_pol_reg && s_rz_reg);
                end else begin
                    s_amp_reg <= s_amp_reg | (drv && mon_amp_ok_i[g]);
                    s_pol_reg <= s_pol_reg | (drv && pol_ok);
                    s_rz_reg  <= s_rz_reg | rz_ok;
                end
            end
        end
    endgenerate

    // unused lanes of the delay words read as zero
    if (NCH < 2 * `CCG_DLY_PER_WORD) begin : g_pad_hi
        assign dly_hi_w[31:(NCH - `CCG_DLY_PER_WORD) * 3] = '0;
    end else begin : g_pad_full
        assign dly_hi_w[31:30] = 2'b00;
    end
    assign dly_lo_w[31:30] = 2'b00;

    // ---------------------------------------------------------------
    // front panel lamps
    // ---------------------------------------------------------------
    ccg_mod_st_t mst_w;
    logic [BKW-1:0] blk_reg;
    logic           blk_ph_reg;
    wire  [3:0]     src_bad = ~ref_good_reg & src_avail;

    // loading or disabled blinks ahead of failure; no reference is a failure
    assign mst_w = (!mod_en || fw_load) ? CCG_ST_BLINK :
                   (!sel_ok)            ? CCG_ST_FAIL  : CCG_ST_OK;

    // blink phase; half period is long, so a parameter can shorten it
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            blk_reg    <= '0;
            blk_ph_reg <= 1'b0;
        end else if (blk_reg == BKW'(BLINK_HALF - 1)) begin
            blk_reg    <= '0;
            blk_ph_reg <= ~blk_ph_reg;
        end else begin
            blk_reg <= blk_reg + 1'b1;
        end
    end

    // amber beats green, so a dead selected source still shows as faulty
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            src_green_o  <= 4'h0;
            src_amber_o  <= 4'h0;
            out_fault_o  <= 1'b0;
            stat_green_o <= 1'b0;
            stat_amber_o <= 1'b0;
        end else begin
            src_amber_o  <= src_bad;
            src_green_o  <= sel_oh & ~src_bad;
            out_fault_o  <= |fail_reg;
            unique case (mst_w)
                CCG_ST_OK: begin
                    stat_green_o <= 1'b1;
                    stat_amber_o <= 1'b0;
                end
                CCG_ST_BLINK: begin
                    stat_green_o <= blk_ph_reg;
                    stat_amber_o <= 1'b0;
                end
                CCG_ST_FAIL: begin
                    stat_green_o <= 1'b0;
                    stat_amber_o <= 1'b1;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // interrupts
    // ---------------------------------------------------------------
    logic [3:0] good_d_reg;
    wire  [NEV-1:0] ev = {good_d_reg & ~ref_good_reg,
                          NCH'(fail_reg & ~fail_d_reg)};
    wire  [NEV-1:0] clr = wr_clr ? wdata_i[NEV-1:0] : '0;

    // set wins over a clear landing in the same cycle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            good_d_reg <= 4'h0;
            fail_d_reg <= '0;
            ist_reg    <= '0;
            irq_o      <= 1'b0;
        end else begin
            good_d_reg <= ref_good_reg;
            fail_d_reg <= fail_reg;
            ist_reg    <= (ist_reg & ~clr) | ev;
            irq_o      <= |(ist_reg & ien_reg);
        end
    end

    // ---------------------------------------------------------------
    // read back
    // ---------------------------------------------------------------
    logic [31:0] rd_w;
    assign rd_w =
        hit(addr_i, `CCG_OFS_CTRL)   ? 32'(ctrl_reg) :
        hit(addr_i, `CCG_OFS_CHEN)   ? 32'(chen_reg) :
        hit(addr_i, `CCG_OFS_DUTY)   ? 32'(duty_reg) :
        hit(addr_i, `CCG_OFS_DLY_LO) ? dly_lo_w :
        hit(addr_i, `CCG_OFS_DLY_HI) ? dly_hi_w :
        hit(addr_i, `CCG_OFS_FAIL)   ? 32'(fail_reg) :
        hit(addr_i, `CCG_OFS_REF)    ? {27'h0, expansion_shelf_i, ref_good_reg} :
        hit(addr_i, `CCG_OFS_IRQ_ST) ? 32'(ist_reg) :
        hit(addr_i, `CCG_OFS_IRQ_EN) ? 32'(ien_reg) : 32'h0;

    // data stand only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) rdata_o <= 32'h0;
        else         rdata_o <= re_i ? rd_w : 32'h0;
    end

endmodule

//--- test/ccg_chk_sva.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// port checker
// ---------------------------------------------------------------
module ccg_chk #(
    parameter int NCH = 20
)(
    input  wire logic            clk_i,
    input  wire logic            rstn_i,
    input  wire logic            re_i,
    input  wire logic [31:0]     rdata_o,
    input  wire logic [3:0]      ref_clk_i,
    input  wire logic            expansion_shelf_i,
    input  wire logic [NCH-1:0]  tip_output_o,
    input  wire logic [NCH-1:0]  ring_output_o,
    input  wire logic [NCH-1:0]  relay_on_o,
    input  wire logic [3:0]      src_green_o,
    input  wire logic [3:0]      src_amber_o,
    input  wire logic            stat_green_o,
    input  wire logic            stat_amber_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    logic [11:0] hi_cnt;
    logic        last_tip;
    // mark length and last mark polarity, channel 0 only to keep it small
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hi_cnt   <= 12'h000;
            last_tip <= 1'b0;
        end else begin
            hi_cnt <= tip_output_o[0] ? hi_cnt + 12'h001 : 12'h000;
            if (tip_output_o[0] || ring_output_o[0]) begin
                last_tip <= tip_output_o[0];
            end
        end
    end

    property p_excl; (tip_output_o & ring_output_o) == '0; endproperty
    a_excl: assert property (p_excl) else $error("tip and ring driven together");
    property p_relay; ((tip_output_o | ring_output_o) & ~relay_on_o & ~$past(relay_on_o)) == '0;
    endproperty
    a_relay: assert property (p_relay) else $error("drive on an open relay");
    property p_width; $fell(tip_output_o[0]) && relay_on_o[0] |->
        (hi_cnt == 12'd1560) || (hi_cnt == 12'd1960); endproperty
    a_width: assert property (p_width) else $error("mark width wrong");
    property p_alt_r; $rose(ring_output_o[0]) |-> last_tip; endproperty
    a_alt_r: assert property (p_alt_r) else $error("two negative marks in a row");
    property p_alt_t; $rose(tip_output_o[0]) |-> !last_tip; endproperty
    a_alt_t: assert property (p_alt_t) else $error("two positive marks in a row");
    property p_align; $rose(ref_clk_i[0]) && src_green_o[0] && relay_on_o[0] |->
        ##[1:4] tip_output_o[0]; endproperty
    a_align: assert property (p_align) else $error("no mark after ref edge");
    property p_lamp; (src_green_o & src_amber_o) == 4'h0; endproperty
    a_lamp: assert property (p_lamp) else $error("source lamp green and amber");
    property p_one; $onehot0(src_green_o); endproperty
    a_one: assert property (p_one) else $error("more than one source selected");
    property p_stat; !(stat_green_o && stat_amber_o); endproperty
    a_stat: assert property (p_stat) else $error("status lamp both colours");
    property p_exp; !(src_green_o[3] && !expansion_shelf_i); endproperty
    a_exp: assert property (p_exp) else $error("expansion source outside shelf");
    property p_rd; rdata_o != 32'h0 |-> $past(re_i); endproperty
    a_rd: assert property (p_rd) else $error("read data without read");

    c_fall: cover property ($fell(tip_output_o[0]));
    c_ring: cover property ($rose(ring_output_o[0]));
    c_blink: cover property ($rose(stat_green_o) ##[1:20] $fell(stat_green_o));
endmodule

bind ccg_top ccg_chk #(.NCH(NCH)) i_chk (
    .clk_i(clk_i), .rstn_i(rstn_i), .re_i(re_i), .rdata_o(rdata_o),
    .ref_clk_i(ref_clk_i), .expansion_shelf_i(expansion_shelf_i),
    .tip_output_o(tip_output_o), .ring_output_o(ring_output_o),
    .relay_on_o(relay_on_o), .src_green_o(src_green_o), .src_amber_o(src_amber_o),
    .stat_green_o(stat_green_o), .stat_amber_o(stat_amber_o)
);

//--- test/ccg_line_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// far-end line sense: what the monitors see on each pair
// ---------------------------------------------------------------
module ccg_line_model #(
    parameter int NCH = 20
)(
    input  wire logic [NCH-1:0]  tip_i,
    input  wire logic [NCH-1:0]  ring_i,
    input  wire logic [NCH-1:0]  relay_i,
    input  wire logic [NCH-1:0]  low_amp_i,
    output logic      [NCH-1:0]  amp_ok_o,
    output logic      [NCH-1:0]  pos_o,
    output logic      [NCH-1:0]  neg_o
);
    // an open relay leaves the pair at zero, so nothing is sensed
    assign pos_o    = tip_i & relay_i;
    assign neg_o    = ring_i & relay_i;
    // weak driver is the only fault the bench commands
    assign amp_ok_o = (pos_o | neg_o) & ~low_amp_i;
endmodule

//--- test/tb_top.sv
`timescale 1ns/1ps
`include "ccg_cfg.svh"
module tb_top;
    import ccg_pkg::*;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    localparam int NCH    = `CCG_NCH;
    localparam int REF_PER = 8 * `CCG_IVL_CYC; // one byte per reference period
    localparam int REF_PH  = 5121;
    logic            clk_i = 1'b0;
    logic            rstn_i = 1'b0;
    logic [7:0]      addr_i = 8'h00;
    logic [31:0]     wdata_i = 32'h0;
    logic            we_i = 1'b0;
    logic            re_i = 1'b0;
    logic [31:0]     rdata_o;
    logic [3:0]      ref_clk_i = 4'h0;
    logic            expansion_shelf_i = 1'b0;
    logic [NCH-1:0]  low_amp = '0;
    logic [NCH-1:0]  amp_ok, pos, neg, tip, ring, relay;
    logic [3:0]      sg, sa, tip_q = 4'h0;
    logic            out_fault, stat_g, stat_a, irq, ring_q = 1'b0;
    int              n_errors = 0, checked = 0, cyc = 0, ring_t = -1;
    int              rise_t[4] = '{-1, -1, -1, -1};
    int              fall_t[4] = '{-1, -1, -1, -1};

    always #2.5 clk_i = ~clk_i;

    ccg_top #(.NCH(NCH), .REF_TIMEOUT(30000), .BLINK_HALF(8)) i_dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .ref_clk_i(ref_clk_i),
        .expansion_shelf_i(expansion_shelf_i), .mon_amp_ok_i(amp_ok),
        .mon_pos_i(pos), .mon_neg_i(neg), .tip_output_o(tip), .ring_output_o(ring),
        .relay_on_o(relay), .src_green_o(sg), .src_amber_o(sa), .out_fault_o(out_fault),
        .stat_green_o(stat_g), .stat_amber_o(stat_a), .irq_o(irq));

    ccg_line_model #(.NCH(NCH)) i_line (
        .tip_i(tip), .ring_i(ring), .relay_i(relay), .low_amp_i(low_amp),
        .amp_ok_o(amp_ok), .pos_o(pos), .neg_o(neg));

    // ---------------------------------------------------------------
    // reference A, edge timing capture and hang guard
    // ---------------------------------------------------------------
    // only A runs; B and C stay missing so their lamps go amber
    always @(posedge clk_i) begin
        cyc          <= cyc + 1;
        ref_clk_i[0] <= ((cyc + REF_PER - REF_PH) % REF_PER) < (REF_PER / 2);
        tip_q        <= tip[3:0];
        ring_q       <= ring[0];
        for (int i = 0; i < 4; i++) begin
            if (tip[i] && !tip_q[i]) rise_t[i] <= cyc;
            if (!tip[i] && tip_q[i]) fall_t[i] <= cyc;
        end
        if (ring[0] && !ring_q) ring_t <= cyc;
        if (cyc > 60000) begin
            n_errors++;
            close_out();
        end
    end

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        we_i    <= 1'b1;
        @(posedge clk_i);
        we_i    <= 1'b0;
    endtask
    // read data are taken at the edge after the strobe edge, their only cycle
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk_i);
        addr_i <= a;
        re_i   <= 1'b1;
        @(posedge clk_i);
        re_i   <= 1'b0;
        @(posedge clk_i);
        chk(rdata_o, exp, what);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset_regs();
        rdchk(`CCG_OFS_CTRL, 32'h4, "ctrl reset");
        rdchk(`CCG_OFS_CHEN, 32'hfffff, "chan enable reset");
        rdchk(`CCG_OFS_DUTY, 32'h0, "duty reset");
        wr(`CCG_OFS_FAIL, 32'hfffff);
        rdchk(`CCG_OFS_FAIL, 32'h0, "fail is read only");
        rdchk(8'h3c, 32'h0, "unmapped read");
        chk(relay, 20'hfffff, "relays after reset");
        chk({stat_g, stat_a, sa[0]}, 3'b011, "lamps without ref");
        $display("test reset_regs done");
    endtask

    task automatic t_pulses();
        wr(`CCG_OFS_DUTY, 32'h2);
        wr(`CCG_OFS_DLY_LO, 32'h1c0);
        wr(`CCG_OFS_CHEN, 32'hffff7);
        repeat (3) @(posedge clk_i);
        chk(relay[3:0], 4'b0111, "one relay opened");
        // second edge aligns; first only proves the reference good
        while (cyc < REF_PH + REF_PER + 3300) @(posedge clk_i);
        chk(fall_t[0] - rise_t[0], `CCG_W50_CYC, "50/50 width");
        chk(fall_t[1] - rise_t[1], `CCG_W62_CYC, "62.5 width");
        chk(rise_t[2] - rise_t[0], 7 * `CCG_DLY_STEP_CYC, "delay code 7");
        chk(ring_t - rise_t[0], `CCG_IVL_CYC, "interval and polarity");
        chk(rise_t[0] - (REF_PH + REF_PER) inside {[1:4]}, 1'b1, "byte start");
        chk(rise_t[3] < `CCG_IVL_CYC, 1'b1, "disabled channel quiet");
        chk({sg, sa}, 8'h16, "source lamps");
        chk({stat_g, stat_a}, 2'b10, "status good");
        rdchk(`CCG_OFS_REF, 32'h1, "ref good");
        $display("test pulses done");
    endtask

    task automatic t_fault();
        @(posedge clk_i);
        low_amp[5] <= 1'b1;
        repeat (2 * `CCG_IVL_CYC + 20) @(posedge clk_i);
        chk(out_fault, 1'b1, "fault lamp on");
        rdchk(`CCG_OFS_FAIL, 32'h20, "only channel 5 failed");
        rdchk(`CCG_OFS_IRQ_ST, 32'h20, "sticky status");
        chk(irq, 1'b0, "irq masked");
        wr(`CCG_OFS_IRQ_EN, 32'h20);
        low_amp[5] <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(irq, 1'b1, "irq enabled");
        repeat (2 * `CCG_IVL_CYC + 20) @(posedge clk_i);
        chk({out_fault, irq}, 2'b01, "fault gone, irq sticky");
        wr(`CCG_OFS_IRQ_CLR, 32'h20);
        repeat (2) @(posedge clk_i);
        chk(irq, 1'b0, "irq cleared");
        rdchk(`CCG_OFS_IRQ_ST, 32'h0, "status cleared");
        $display("test fault done");
    endtask

    task automatic t_blink();
        logic [31:0] codes[2];
        int          toggles;
        logic        prev;
        codes = '{32'h0c, 32'h10};
        @(negedge tip[0]);
        expansion_shelf_i <= 1'b1;
        foreach (codes[k]) begin
            wr(`CCG_OFS_CTRL, codes[k]);
            toggles = 0;
            repeat (3) @(posedge clk_i);
            prev = stat_g;
            for (int c = 0; c < 40; c++) begin
                @(posedge clk_i);
                if (stat_g !== prev) toggles++;
                prev = stat_g;
            end
            chk(toggles >= 4, 1'b1, "status blinks");
        end
        chk({sa, relay}, 24'ha00000, "relays open, C off, D amber");
        $display("test blink done");
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        t_reset_regs();
        t_pulses();
        t_fault();
        t_blink();
        close_out();
    end
endmodule
